// ---- hdl/ccv_pkg.sv ----
// Package of constants and carrier types for the core context and vector register bank.
`default_nettype none
package ccv_pkg;
   // ----------------------------------------------------------------------
   // Register addresses (core special-function address space).
   // ----------------------------------------------------------------------
   localparam logic [15:0] CCV_SYSTEM_CONFIGURATION_ADDR = 16'hFE14;
   localparam logic [15:0] CCV_IVB_ADDR = 16'hFE20;
   localparam logic [15:0] CCV_TVB_ADDR = 16'hFE24;
   localparam logic [15:0] CCV_ISP_ADDR = 16'hFE28;
   localparam logic [15:0] CCV_ICR_ADDR = 16'hFE2C;
   localparam logic [15:0] CCV_LIMIT_ADDR = 16'hFE3C;
   // ----------------------------------------------------------------------
   // Field positions and reset values.
   // ----------------------------------------------------------------------
   localparam int CCV_OFS_MSB = 15;
   localparam int CCV_SEG_LSB = 16;
   localparam int CCV_SEG_MSB = 19;
   localparam int CCV_SYS_FLAG_BIT = 0;
   localparam int CCV_SYS_PROT_BIT = 1;
   localparam int CCV_ICR_PRIO_MSB = 7;
   localparam int CCV_ICR_IE_BIT = 8;
   localparam int CCV_ICR_PEND_LSB = 16;
   localparam int CCV_ICR_PEND_MSB = 23;
   localparam int CCV_ICR_ARB_LSB = 24;
   localparam int CCV_ICR_ARB_MSB = 25;
   localparam logic [31:0] CCV_LIMIT_MASK = 32'h000FFFFF;
   localparam logic [31:0] CCV_EVEN_MASK = 32'hFFFFFFFE;
   localparam logic [31:0] CCV_ICR_MASK = 32'h03FF01FF;
   localparam logic [31:0] CCV_SYS_MASK = 32'h00000003;
   localparam logic [31:0] CCV_LIMIT_RST = 32'h00000000;
   localparam logic [31:0] CCV_ISP_RST = 32'h00000100;
   localparam logic [31:0] CCV_IVB_RST = 32'h00000000;
   localparam logic [31:0] CCV_TVB_RST = 32'hA0000100;
   localparam logic [31:0] CCV_ICR_RST = 32'h00000000;
   localparam logic [31:0] CCV_SYS_RST = 32'h00000000;
   // Save area stride: sixteen words of four bytes, as a shift of six.
   localparam int CCV_CSA_SHIFT = 6;
   // Trap vector slot for the context-management trap class.
   localparam logic [31:0] CCV_DEPL_TRAP_OFS = 32'h00000060;
   // ----------------------------------------------------------------------
   // Carrier types.
   // ----------------------------------------------------------------------
   // Register access request from the core.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } ccv_req_t;
   // Context save request: head pointer consumed and the normal target.
   typedef struct packed {
      logic valid;
      logic irq_entry;
      logic [19:0] head_ptr;
      logic [31:0] target;
   } ccv_save_t;
endpackage : ccv_pkg
`default_nettype wire

// ---- hdl/ccv_regs.sv ----
// Core context, stack and vector register bank with depletion detection.
`default_nettype none
module ccv_regs (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset,
   // Register access from the core.
   input wire ccv_pkg::ccv_req_t req,
   output logic [31:0] rdata,
   // Initialization protection open (driven from the watchdog, same clock).
   input wire logic init_open,
   // Context save and restore from the core pipeline.
   input wire ccv_pkg::ccv_save_t save,
   input wire logic irq_return,
   input wire logic [31:0] restored_sp,
   // Results toward the core.
   output logic save_done,
   output logic [31:0] branch_target,
   output logic depletion_trap,
   output logic [31:0] csa_addr,
   output logic [31:0] address_reg_ten,
   output logic protection_enable
);
   import ccv_pkg::*;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   // Byte address of a save area: segment in top nibble, offset times 64.
   function automatic logic [31:0] ccv_csa_addr(input logic [19:0] p);
      ccv_csa_addr = {p[CCV_SEG_MSB:CCV_SEG_LSB], 6'h00,
                      p[CCV_OFS_MSB:0], 6'h00};
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   logic [31:0] limit_q, limit_d;   // Save area limit pointer.
   logic [31:0] isp_q, isp_d;       // Interrupt stack pointer.
   logic [31:0] ivb_q, ivb_d;       // Interrupt vector base.
   logic [31:0] tvb_q, tvb_d;       // Trap vector base.
   logic [31:0] icr_q, icr_d;       // Interrupt control.
   logic [31:0] sys_q, sys_d;       // System configuration.
   logic [31:0] sp_q, sp_d;         // Stack pointer copy.
   logic done_q, done_d;            // One-cycle save completion pulse.
   logic trap_q, trap_d;            // One-cycle depletion trap pulse.
   logic [31:0] tgt_q, tgt_d;       // Branch target of the last save.
   logic [31:0] csa_q, csa_d;       // Byte address of the last save area used.
   logic depl_hit;                  // Head pointer matches limit this cycle.
   // The compare looks only at the twenty pointer bits of the limit, so a
   // stale value in the reserved upper bits could never mask a depletion.
   // Those bits are kept at zero by the write mask in any case.

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------
   // Writes are masked so reserved positions never store a one; the
   // hardware set of the sticky flag is applied last so it beats a clear.
   always_comb begin
      limit_d = limit_q;
      isp_d = isp_q;
      ivb_d = ivb_q;
      tvb_d = tvb_q;
      icr_d = icr_q;
      sys_d = sys_q;
      sp_d = sp_q;
      depl_hit = save.valid && (save.head_ptr == limit_q[CCV_SEG_MSB:0]);
      done_d = save.valid;
      trap_d = depl_hit;
      tgt_d = tgt_q;
      csa_d = csa_q;
      if (req.wr) begin
         unique case (req.addr)
            CCV_LIMIT_ADDR: limit_d = req.wdata & CCV_LIMIT_MASK;
            CCV_ISP_ADDR: if (init_open) isp_d = req.wdata & CCV_EVEN_MASK;
            CCV_IVB_ADDR: if (init_open) ivb_d = req.wdata & CCV_EVEN_MASK;
            CCV_TVB_ADDR: if (init_open) tvb_d = req.wdata & CCV_EVEN_MASK;
            CCV_ICR_ADDR: icr_d = req.wdata & CCV_ICR_MASK;
            CCV_SYSTEM_CONFIGURATION_ADDR: sys_d = req.wdata & CCV_SYS_MASK;
            default: ;
         endcase
      end
      // A save always completes; the head area address is reported.
      if (save.valid) begin
         csa_d = ccv_csa_addr(save.head_ptr);
         tgt_d = depl_hit ? (tvb_q | CCV_DEPL_TRAP_OFS) : save.target;
         // Interrupt entry: old stack pointer is in the saved context,
         // then the stack pointer takes the interrupt stack value.
         if (save.irq_entry) sp_d = isp_q;
      end
      if (irq_return) sp_d = restored_sp;
      if (depl_hit) sys_d[CCV_SYS_FLAG_BIT] = 1'b1;
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         limit_q <= CCV_LIMIT_RST;
         isp_q <= CCV_ISP_RST;
         ivb_q <= CCV_IVB_RST;
         tvb_q <= CCV_TVB_RST;
         icr_q <= CCV_ICR_RST;
         sys_q <= CCV_SYS_RST;
         sp_q <= 32'h00000000;
         done_q <= 1'b0;
         trap_q <= 1'b0;
         tgt_q <= 32'h00000000;
         csa_q <= 32'h00000000;
      end else begin
         limit_q <= limit_d;
         isp_q <= isp_d;
         ivb_q <= ivb_d;
         tvb_q <= tvb_d;
         icr_q <= icr_d;
         sys_q <= sys_d;
         sp_q <= sp_d;
         done_q <= done_d;
         trap_q <= trap_d;
         tgt_q <= tgt_d;
         csa_q <= csa_d;
      end
   end

   // -------------------------------------------------------------------------
   // Read path and outputs
   // -------------------------------------------------------------------------
   // Reads are combinational; unmapped addresses return zero.
   always_comb begin
      rdata = 32'h00000000;
      if (req.rd) begin
         unique case (req.addr)
            CCV_LIMIT_ADDR: rdata = limit_q;
            CCV_ISP_ADDR: rdata = isp_q;
            CCV_IVB_ADDR: rdata = ivb_q;
            CCV_TVB_ADDR: rdata = tvb_q;
            CCV_ICR_ADDR: rdata = icr_q;
            CCV_SYSTEM_CONFIGURATION_ADDR: rdata = sys_q;
            default: rdata = 32'h00000000;
         endcase
      end
   end

   assign save_done = done_q;
   assign depletion_trap = trap_q;
   assign branch_target = tgt_q;
   assign csa_addr = csa_q;
   assign address_reg_ten = sp_q;
   assign protection_enable = sys_q[CCV_SYS_PROT_BIT];

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   // All checks run on the core clock and sleep while reset is high; the
   // inputs they read come from logic on the same clock, so no settling
   // margin is needed.

   // Depletion detection and the redirected branch target.
   chk_depl_trap: assert property (
      @(posedge ref_clk) disable iff (reset)
      save.valid && save.head_ptr == limit_q[19:0] |=> depletion_trap && save_done)
      else $error("depletion trap missing");
   chk_no_false_trap: assert property (
      @(posedge ref_clk) disable iff (reset)
      !(save.valid && save.head_ptr == limit_q[19:0]) |=> !depletion_trap)
      else $error("depletion trap without a match");
   chk_trap_target: assert property (
      @(posedge ref_clk) disable iff (reset)
      depletion_trap |-> branch_target == ($past(tvb_q) | CCV_DEPL_TRAP_OFS))
      else $error("trap target wrong");
   chk_normal_target: assert property (
      @(posedge ref_clk) disable iff (reset)
      save.valid && !depl_hit |=> branch_target == $past(save.target))
      else $error("normal target wrong");
   // A save completes whether or not it traps, and never without a request.
   chk_save_done: assert property (
      @(posedge ref_clk) disable iff (reset)
      !save.valid |=> !save_done)
      else $error("save done without a save");

   // Sticky depletion flag: set by hardware, cleared only by a write.
   chk_sticky_set: assert property (
      @(posedge ref_clk) disable iff (reset)
      depletion_trap |-> sys_q[CCV_SYS_FLAG_BIT])
      else $error("sticky flag not set");
   chk_sticky_hold: assert property (
      @(posedge ref_clk) disable iff (reset)
      sys_q[0] && !(req.wr && req.addr == CCV_SYSTEM_CONFIGURATION_ADDR) |=> sys_q[0])
      else $error("sticky flag dropped");
   // A configuration write with no depletion in the same cycle stores
   // exactly the two defined bits of the written word.
   chk_sys_write: assert property (
      @(posedge ref_clk) disable iff (reset)
      req.wr && req.addr == CCV_SYSTEM_CONFIGURATION_ADDR && !depl_hit
      |=> sys_q == ($past(req.wdata) & CCV_SYS_MASK))
      else $error("configuration write wrong");

   // Initialization protection of the stack pointer and vector bases.
   chk_protect_write: assert property (
      @(posedge ref_clk) disable iff (reset)
      req.wr && !init_open && req.addr == CCV_TVB_ADDR |=> $stable(tvb_q))
      else $error("protected write taken");
   chk_protect_isp: assert property (
      @(posedge ref_clk) disable iff (reset)
      req.wr && !init_open && req.addr == CCV_ISP_ADDR |=> $stable(isp_q))
      else $error("protected stack write taken");
   chk_protect_ivb: assert property (
      @(posedge ref_clk) disable iff (reset)
      req.wr && !init_open && req.addr == CCV_IVB_ADDR |=> $stable(ivb_q))
      else $error("protected vector write taken");
   // An open write of the trap base lands with only bit zero dropped.
   chk_open_write: assert property (
      @(posedge ref_clk) disable iff (reset)
      req.wr && init_open && req.addr == CCV_TVB_ADDR
      |=> tvb_q == ($past(req.wdata) & CCV_EVEN_MASK))
      else $error("open trap base write lost");

   // Fixed-zero and reserved positions.
   chk_isp_even: assert property (
      @(posedge ref_clk) disable iff (reset)
      isp_q[0] == 1'b0 && ivb_q[0] == 1'b0 && tvb_q[0] == 1'b0)
      else $error("odd vector or stack");
   chk_reserved_zero: assert property (
      @(posedge ref_clk) disable iff (reset)
      (sys_q[31:2] == 30'h0) && (limit_q[31:20] == 12'h000))
      else $error("reserved bit set");
   chk_icr_reserved: assert property (
      @(posedge ref_clk) disable iff (reset)
      (icr_q & ~CCV_ICR_MASK) == 32'h00000000)
      else $error("control register reserved bit set");

   // Stack pointer switch on interrupt entry and return.
   chk_sp_switch: assert property (
      @(posedge ref_clk) disable iff (reset)
      save.valid && save.irq_entry && !irq_return |=> address_reg_ten == $past(isp_q))
      else $error("stack switch missing");
   chk_sp_restore: assert property (
      @(posedge ref_clk) disable iff (reset)
      irq_return |=> address_reg_ten == $past(restored_sp))
      else $error("stack restore missing");

   // Save area addresses step in whole areas of sixteen words.
   chk_csa_stride: assert property (
      @(posedge ref_clk) disable iff (reset)
      save_done |-> csa_addr[5:0] == 6'h00)
      else $error("save area misaligned");

   // Main scenarios that a useful run must reach.
   cov_depletion: cover property (@(posedge ref_clk) disable iff (reset) depletion_trap);
   cov_irq_return: cover property (@(posedge ref_clk) disable iff (reset) irq_return);
   cov_irq_entry: cover property (@(posedge ref_clk) disable iff (reset)
      save.valid && save.irq_entry);
   cov_blocked: cover property (@(posedge ref_clk) disable iff (reset)
      req.wr && !init_open && req.addr == CCV_ISP_ADDR);
   cov_prot_on: cover property (@(posedge ref_clk) disable iff (reset) protection_enable);
endmodule : ccv_regs
`default_nettype wire

// ---- test/ccv_regs_tb.sv ----
// Self-checking testbench for the core context and vector register bank.
`default_nettype none
module ccv_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ccv_pkg::*;
   // ------------------------------------------------------------
   // Signals and counters.
   // ------------------------------------------------------------
   logic ref_clk, reset, init_open, irq_return, save_done, depletion_trap, protection_enable;
   ccv_req_t req;
   ccv_save_t save;
   logic [31:0] rdata, restored_sp, branch_target, csa_addr, address_reg_ten;
   int n_errors = 0;
   int check_count = 0;
   // Registers walked in the mask pass, and their readable bits.
   logic [15:0] a_tab [5] = '{CCV_IVB_ADDR, CCV_TVB_ADDR, CCV_ISP_ADDR, CCV_ICR_ADDR,
      CCV_LIMIT_ADDR};
   logic [31:0] m_tab [5] = '{CCV_EVEN_MASK, CCV_EVEN_MASK, CCV_EVEN_MASK, CCV_ICR_MASK,
      CCV_LIMIT_MASK};
   ccv_regs u_ccv_regs (.ref_clk(ref_clk), .reset(reset), .req(req), .rdata(rdata),
      .init_open(init_open), .save(save), .irq_return(irq_return), .restored_sp(restored_sp),
      .save_done(save_done), .branch_target(branch_target), .depletion_trap(depletion_trap),
      .csa_addr(csa_addr), .address_reg_ten(address_reg_ten),
      .protection_enable(protection_enable));
   // ------------------------------------------------------------
   // Clock, closing task and bus tasks.
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // A write is taken at one rising edge; a spare cycle keeps strobes apart.
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge ref_clk);
      req.wr = 1'b0;
      @(negedge ref_clk);
   endtask
   // Read data is combinational, so it is looked at inside the same cycle.
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      #1 check("rdata", rdata, exp);
      @(negedge ref_clk);
   endtask
   // One save per call; valid is left high so saves may run back to back.
   task automatic sv(input logic [19:0] h, input logic irq, input logic [31:0] t,
      input logic trap, input logic [31:0] bt);
      save = '{valid: 1'b1, irq_entry: irq, head_ptr: h, target: t};
      @(negedge ref_clk);
      check("save_done", {31'h0, save_done}, 32'h1);
      check("trap", {31'h0, depletion_trap}, {31'h0, trap});
      check("branch_target", branch_target, bt);
      check("csa_addr", csa_addr, {h[19:16], 6'h0, h[15:0], 6'h0});
   endtask
   // A hang is cut short well past the sixty or so cycles the tests need.
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_errors++;
      report_and_stop();
   end
   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      init_open = 1'b1;
      irq_return = 1'b0;
      restored_sp = 32'h0;
      req = '0;
      save = '0;
      repeat (4) @(negedge ref_clk);
      reset = 1'b0;
      rd(CCV_TVB_ADDR, 32'hA0000100);
      rd(CCV_ISP_ADDR, CCV_ISP_RST);
      rd(CCV_SYSTEM_CONFIGURATION_ADDR, 32'h0);
      // All ones land only in the documented fields.
      foreach (a_tab[i]) begin
         wr(a_tab[i], 32'hFFFFFFFF);
         rd(a_tab[i], m_tab[i]);
      end
      // With protection closed the three guarded registers keep their values.
      init_open = 1'b0;
      foreach (a_tab[i]) begin
         wr(a_tab[i], 32'h0);
         rd(a_tab[i], (i < 3) ? m_tab[i] : 32'h0);
      end
      wr(16'hFE00, 32'hFFFFFFFF);
      rd(16'hFE00, 32'h0);
      init_open = 1'b1;
      wr(CCV_TVB_ADDR, 32'h80000201);
      wr(CCV_ISP_ADDR, 32'h00004445);
      wr(CCV_LIMIT_ADDR, 32'h00030010);
      // Last free area but one, then the last one: trap on the second only.
      sv(20'h3000F, 1'b0, 32'h12345678, 1'b0, 32'h12345678);
      sv(20'h30010, 1'b0, 32'h12345678, 1'b1, 32'h80000260);
      save = '0;
      @(negedge ref_clk);
      check("trap_pulse", {31'h0, depletion_trap}, 32'h0);
      rd(CCV_SYSTEM_CONFIGURATION_ADDR, 32'h1);
      rd(CCV_SYSTEM_CONFIGURATION_ADDR, 32'h1);
      // No protection sets exist here, so enabling needs no setup first.
      wr(CCV_SYSTEM_CONFIGURATION_ADDR, 32'hFFFFFFFE);
      rd(CCV_SYSTEM_CONFIGURATION_ADDR, 32'h2);
      check("protection_enable", {31'h0, protection_enable}, 32'h1);
      // Interrupt entry loads the stack pointer; return brings the old one back.
      sv(20'h00001, 1'b1, 32'h00000400, 1'b0, 32'h00000400);
      check("sp_entry", address_reg_ten, 32'h00004444);
      save = '0;
      irq_return = 1'b1;
      restored_sp = 32'hABCD0000;
      @(negedge ref_clk);
      irq_return = 1'b0;
      check("sp_return", address_reg_ten, 32'hABCD0000);
      // A reset in mid-run brings back the trap base, interrupt stack, configuration and stack pointer reset values.
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      rd(CCV_TVB_ADDR, 32'hA0000100);
      rd(CCV_ISP_ADDR, CCV_ISP_RST);
      rd(CCV_SYSTEM_CONFIGURATION_ADDR, 32'h0);
      check("sp_reset", address_reg_ten, 32'h0);
      check("prot_reset", {31'h0, protection_enable}, 32'h0);
      report_and_stop();
   end
endmodule // ccv_regs_tb
`default_nettype wire
